/* dv/pin_model.sv */
module pin_model (
   input wire gpio_port_pkg::pins_type pinOut,
   input wire gpio_port_pkg::pins_type pinOe_n,
   input wire gpio_port_pkg::pins_type pullUpEn,
   input wire gpio_port_pkg::pins_type pullDownEn,
   input wire gpio_port_pkg::pins_type extLevel,
   output gpio_port_pkg::pins_type pinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   import gpio_port_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // Own driver wins, then a pull, else the board level
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pinIn[i] = !pinOe_n[i] ? pinOut[i] : pullUpEn[i] ? 1'b1 :
            pullDownEn[i] ? 1'b0 : extLevel[i];
      end
   end
endmodule : pin_model

/* dv/tb_two_pin_gpio_port.sv */
`include "gpio_port_defs.svh"
module tb_two_pin_gpio_port;
   timeunit 1ns;
   timeprecision 1ns;
   import gpio_port_pkg::*;
   logic clk = 0, rst_n, wrStb, rdStb, irq;
   logic [7:0] addr;
   byte_type wrData, rdData, d;
   pins_type pinIn, pinOut, pinOe_n, reducedDrive, pullUpEn, pullDownEn;
   pins_type wiredOrMode, extLevel;
   int miscompares = 0, num_checks = 0;
   always #50 clk = ~clk;
   two_pin_gpio_port dut_u (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
      .reducedDrive(reducedDrive), .pullUpEn(pullUpEn),
      .pullDownEn(pullDownEn), .wiredOrMode(wiredOrMode), .irq(irq));
   pin_model pins_u (.pinOut(pinOut), .pinOe_n(pinOe_n),
      .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extLevel(extLevel),
      .pinIn(pinIn));
   ////////////////////////////////////////////////////////////////////
   task wr(input byte_type a, input byte_type v);
      @(posedge clk);
      addr <= a; wrData <= v; wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
      #1;
   endtask : wr
   task rd(input byte_type a);
      @(posedge clk);
      addr <= a; rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1 d = rdData;
   endtask : rd
   // Sync stages plus edge detect, with margin
   task wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task chk(input string n, input byte_type s, input byte_type e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task end_sim;
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 0; wrStb = 0; rdStb = 0; addr = 0; wrData = 0;
      wiredOrMode = 0; extLevel = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 8'h28; a <= 8'h30; a++) begin
         rd(8'(a)); chk("reset read", d, 8'h00);
      end
      wr(`OFS_DIRECTION, 8'hff); wr(`OFS_OUT_DATA, 8'hbf);
      rd(`OFS_OUT_DATA); chk("out data", d, 8'h80);
      chk("oe_n", {6'h0, pinOe_n}, 8'h00);
      wt(3); wr(`OFS_READBACK, 8'hff);
      rd(`OFS_READBACK); chk("readback", d, 8'h80);
      wr(`OFS_DRIVE, 8'hc0); chk("drive out", {6'h0, reducedDrive}, 8'h03);
      wr(`OFS_DIRECTION, 8'h00); extLevel <= 2'b01; wt(3);
      chk("drive in", {6'h0, reducedDrive}, 8'h00);
      rd(`OFS_OUT_DATA); chk("in data", d, 8'h40);
      wr(`OFS_PULL_EN, 8'hc0); wr(`OFS_POLARITY, 8'h40);
      chk("pull up", {6'h0, pullUpEn}, 8'h02);
      chk("pull down", {6'h0, pullDownEn}, 8'h01);
      wr(`OFS_DIRECTION, 8'hc0);
      chk("pull pushpull", {6'h0, pullUpEn}, 8'h00);
      wiredOrMode <= 2'b11; wt(1);
      chk("pull wired", {6'h0, pullUpEn}, 8'h02);
      wiredOrMode <= 2'b00; wr(`OFS_DIRECTION, 8'h00);
      wr(`OFS_PULL_EN, 8'h00); wt(4);
      // Config churn above left stray edges behind
      wr(`OFS_IRQ_FLAGS, 8'hc0); wr(`OFS_IRQ_EN, 8'h40);
      extLevel <= 2'b00; wt(4);
      rd(`OFS_IRQ_FLAGS); chk("no edge", d, 8'h00);
      extLevel <= 2'b01; wt(4);
      rd(`OFS_IRQ_FLAGS); chk("rise flag", d, 8'h40);
      chk("irq on", {7'h0, irq}, 8'h01);
      wr(`OFS_IRQ_FLAGS, 8'h00);
      rd(`OFS_IRQ_FLAGS); chk("write zero", d, 8'h40);
      extLevel <= 2'b11; wt(4); extLevel <= 2'b01; wt(4);
      rd(`OFS_IRQ_FLAGS); chk("fall flag", d, 8'hc0);
      wr(`OFS_IRQ_FLAGS, 8'h40);
      rd(`OFS_IRQ_FLAGS); chk("clear one", d, 8'h80);
      wt(1); chk("irq masked", {7'h0, irq}, 8'h00);
      wr(`OFS_IRQ_EN, 8'hc0); wt(1);
      chk("irq or", {7'h0, irq}, 8'h01);
      end_sim();
   end
endmodule : tb_two_pin_gpio_port

/* hdl/gpio_port_defs.svh */
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

`define ADDR_W 8
`define OFS_OUT_DATA 8'h28
`define OFS_READBACK 8'h29
`define OFS_DIRECTION 8'h2a
`define OFS_DRIVE 8'h2b
`define OFS_PULL_EN 8'h2c
`define OFS_POLARITY 8'h2d
`define OFS_IRQ_EN 8'h2e
`define OFS_IRQ_FLAGS 8'h2f
`define PIN_HI 7
`define PIN_LO 6
`define CFG_RESET 2'h0
`define SYNC_STAGES 2

`endif

/* hdl/gpio_port_pkg.sv */
package gpio_port_pkg;
   typedef logic [7:0] byte_type;
   typedef logic [1:0] pins_type;
endpackage : gpio_port_pkg

/* hdl/two_pin_gpio_port.sv */
`include "gpio_port_defs.svh"

module two_pin_gpio_port (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`ADDR_W-1:0] addr,
   input wire gpio_port_pkg::byte_type wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output gpio_port_pkg::byte_type rdData,
   input wire gpio_port_pkg::pins_type pinIn,
   output gpio_port_pkg::pins_type pinOut,
   output gpio_port_pkg::pins_type pinOe_n,
   output gpio_port_pkg::pins_type reducedDrive,
   output gpio_port_pkg::pins_type pullUpEn,
   output gpio_port_pkg::pins_type pullDownEn,
   input wire gpio_port_pkg::pins_type wiredOrMode,
   output logic irq
);
   import gpio_port_pkg::*;

   pins_type outData_reg;
   pins_type dir_reg;
   pins_type drive_reg;
   pins_type pullEn_reg;
   pins_type polarity_reg;
   pins_type irqEn_reg;
   pins_type flags_reg;
   pins_type flags_next;
   pins_type syncA_reg;
   pins_type syncB_reg;
   pins_type prev_reg;
   pins_type edgeHit;
   pins_type wrBits;
   byte_type rdData_next;

   assign wrBits = wrData[`PIN_HI:`PIN_LO];

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers, writable at any time
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outData_reg <= `CFG_RESET;
         dir_reg <= `CFG_RESET;
         drive_reg <= `CFG_RESET;
         pullEn_reg <= `CFG_RESET;
         polarity_reg <= `CFG_RESET;
         irqEn_reg <= `CFG_RESET;
      end else if (wrStb) begin
         case (addr)
            `OFS_OUT_DATA: outData_reg <= wrBits;
            `OFS_DIRECTION: dir_reg <= wrBits;
            `OFS_DRIVE: drive_reg <= wrBits;
            `OFS_PULL_EN: pullEn_reg <= wrBits;
            `OFS_POLARITY: polarity_reg <= wrBits;
            `OFS_IRQ_EN: irqEn_reg <= wrBits;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers; pad resolves the analog side
   assign pinOut = outData_reg;
   assign pinOe_n = ~dir_reg;
   assign reducedDrive = drive_reg & dir_reg;
   // Pull only on inputs or wired-or outputs
   always_comb begin
      pins_type usable;
      usable = ~dir_reg | wiredOrMode;
      pullUpEn = pullEn_reg & usable & ~polarity_reg;
      pullDownEn = pullEn_reg & usable & polarity_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-stage sync; readback lags direction changes by up to two cycles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_reg <= `CFG_RESET;
         syncB_reg <= `CFG_RESET;
         prev_reg <= `CFG_RESET;
      end else begin
         syncA_reg <= pinIn;
         syncB_reg <= syncA_reg;
         prev_reg <= syncB_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge flags; set wins over a simultaneous clear
   assign edgeHit = (polarity_reg & syncB_reg & ~prev_reg)
      | (~polarity_reg & ~syncB_reg & prev_reg);

   always_comb begin
      flags_next = flags_reg;
      if (wrStb && addr == `OFS_IRQ_FLAGS)
         flags_next = flags_next & ~wrBits;
      flags_next = flags_next | edgeHit;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         flags_reg <= `CFG_RESET;
      else
         flags_reg <= flags_next;
   end

   assign irq = |(flags_reg & irqEn_reg);

   ////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe
   always_comb begin
      rdData_next = 8'h00;
      case (addr)
         `OFS_OUT_DATA: rdData_next[`PIN_HI:`PIN_LO] =
            (dir_reg & outData_reg) | (~dir_reg & syncB_reg);
         `OFS_READBACK: rdData_next[`PIN_HI:`PIN_LO] = syncB_reg;
         `OFS_DIRECTION: rdData_next[`PIN_HI:`PIN_LO] = dir_reg;
         `OFS_DRIVE: rdData_next[`PIN_HI:`PIN_LO] = drive_reg;
         `OFS_PULL_EN: rdData_next[`PIN_HI:`PIN_LO] = pullEn_reg;
         `OFS_POLARITY: rdData_next[`PIN_HI:`PIN_LO] = polarity_reg;
         `OFS_IRQ_EN: rdData_next[`PIN_HI:`PIN_LO] = irqEn_reg;
         `OFS_IRQ_FLAGS: rdData_next[`PIN_HI:`PIN_LO] = flags_reg;
         default: rdData_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rdData <= 8'h00;
      else if (rdStb)
         rdData <= rdData_next;
      else
         rdData <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions, edge flags
   a_flag_sets_edge: assert property (
      @(posedge clk) disable iff (!rst_n)
      edgeHit[0] |=> flags_reg[0])
      else $error("edge did not set flag 0");

   a_flag_sets_edge1: assert property (
      @(posedge clk) disable iff (!rst_n)
      edgeHit[1] |=> flags_reg[1])
      else $error("edge did not set flag 1");

   a_no_stray_flag0: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!flags_reg[0] && !edgeHit[0]) |=> !flags_reg[0])
      else $error("flag 0 set without edge");

   a_no_stray_flag1: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!flags_reg[1] && !edgeHit[1]) |=> !flags_reg[1])
      else $error("flag 1 set without edge");

   a_prev_follows: assert property (
      @(posedge clk) disable iff (!rst_n)
      prev_reg == $past(syncB_reg))
      else $error("edge history stage wrong");

   a_rise_edge0: assert property (
      @(posedge clk) disable iff (!rst_n)
      (polarity_reg[0] && syncB_reg[0] && !prev_reg[0]) |=> flags_reg[0])
      else $error("rising edge missed on pin 6");

   a_fall_edge1: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!polarity_reg[1] && !syncB_reg[1] && prev_reg[1]) |=> flags_reg[1])
      else $error("falling edge missed on pin 7");

   a_flag_w1c: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrStb && addr == `OFS_IRQ_FLAGS && wrData[6] && !edgeHit[0])
      |=> !flags_reg[0])
      else $error("write one did not clear flag");

   a_flag_w1c1: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrStb && addr == `OFS_IRQ_FLAGS && wrData[7] && !edgeHit[1])
      |=> !flags_reg[1])
      else $error("write one did not clear flag 1");

   a_flag_w0_keep: assert property (
      @(posedge clk) disable iff (!rst_n)
      (flags_reg[1] && !(wrStb && addr == `OFS_IRQ_FLAGS && wrData[7]))
      |=> flags_reg[1])
      else $error("flag dropped without clear");

   a_flag_w0_keep0: assert property (
      @(posedge clk) disable iff (!rst_n)
      (flags_reg[0] && !(wrStb && addr == `OFS_IRQ_FLAGS && wrData[6]))
      |=> flags_reg[0])
      else $error("flag 0 dropped without clear");

   a_set_wins0: assert property (
      @(posedge clk) disable iff (!rst_n)
      (edgeHit[0] && wrStb && addr == `OFS_IRQ_FLAGS && wrData[6])
      |=> flags_reg[0])
      else $error("clear beat a new edge");

   ////////////////////////////////////////////////////////////////////////
   // Assertions, interrupt line
   a_irq_level: assert property (
      @(posedge clk) disable iff (!rst_n)
      irq == |(flags_reg & irqEn_reg))
      else $error("irq mismatch");

   a_irq_pin0: assert property (
      @(posedge clk) disable iff (!rst_n)
      (flags_reg[0] && irqEn_reg[0]) |-> irq)
      else $error("enabled flag 0 gave no irq");

   a_irq_pin1: assert property (
      @(posedge clk) disable iff (!rst_n)
      (flags_reg[1] && irqEn_reg[1]) |-> irq)
      else $error("enabled flag 1 gave no irq");

   a_irq_mask0: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!irqEn_reg[0] && !(flags_reg[1] && irqEn_reg[1])) |-> !irq)
      else $error("masked pin 6 raised irq");

   a_irq_mask1: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!irqEn_reg[1] && !(flags_reg[0] && irqEn_reg[0])) |-> !irq)
      else $error("masked pin 7 raised irq");

   a_irq_none: assert property (
      @(posedge clk) disable iff (!rst_n)
      (flags_reg == 2'b00) |-> !irq)
      else $error("irq without any flag");

   ////////////////////////////////////////////////////////////////////////
   // Assertions, register access
   a_read_data: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rdStb && addr == `OFS_OUT_DATA && dir_reg[1])
      |=> rdData[7] == $past(outData_reg[1]))
      else $error("output pin read wrong");

   a_read_out6: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rdStb && addr == `OFS_OUT_DATA && dir_reg[0])
      |=> rdData[6] == $past(outData_reg[0]))
      else $error("output pin 6 read wrong");

   a_read_in6: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rdStb && addr == `OFS_OUT_DATA && !dir_reg[0])
      |=> rdData[6] == $past(syncB_reg[0]))
      else $error("input pin 6 read wrong");

   a_read_in7: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rdStb && addr == `OFS_OUT_DATA && !dir_reg[1])
      |=> rdData[7] == $past(syncB_reg[1]))
      else $error("input pin 7 read wrong");

   a_readback_pin: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rdStb && addr == `OFS_READBACK) |=>
      rdData[7:6] == $past(syncB_reg))
      else $error("readback wrong");

   a_readback_ro: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrStb && addr == `OFS_READBACK) |=>
      ($stable(outData_reg) && $stable(dir_reg)))
      else $error("readback write changed state");

   a_low_bits_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      rdData[5:0] == 6'h00)
      else $error("unused bits nonzero");

   a_rd_idle_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      !rdStb |=> rdData == 8'h00)
      else $error("read data outside its cycle");

   a_cfg_write_dir: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrStb && addr == `OFS_DIRECTION) |=> dir_reg == $past(wrData[7:6]))
      else $error("direction write lost");

   a_cfg_write_pull: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrStb && addr == `OFS_PULL_EN) |=> pullEn_reg == $past(wrData[7:6]))
      else $error("pull enable write lost");

   a_cfg_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      !wrStb |=> ($stable(dir_reg) && $stable(polarity_reg)))
      else $error("config changed without write");

   ////////////////////////////////////////////////////////////////////////
   // Assertions, pin drivers
   a_oe_dir0: assert property (
      @(posedge clk) disable iff (!rst_n)
      pinOe_n[0] == !dir_reg[0])
      else $error("pin 6 enable wrong");

   a_oe_dir1: assert property (
      @(posedge clk) disable iff (!rst_n)
      pinOe_n[1] == !dir_reg[1])
      else $error("pin 7 enable wrong");

   a_pin_out: assert property (
      @(posedge clk) disable iff (!rst_n)
      pinOut == outData_reg)
      else $error("pin output not the latch");

   a_drive_input: assert property (
      @(posedge clk) disable iff (!rst_n)
      !dir_reg[1] |-> !reducedDrive[1])
      else $error("reduced drive on input");

   a_drive_input0: assert property (
      @(posedge clk) disable iff (!rst_n)
      !dir_reg[0] |-> !reducedDrive[0])
      else $error("reduced drive on input 6");

   a_drive_out0: assert property (
      @(posedge clk) disable iff (!rst_n)
      dir_reg[0] |-> reducedDrive[0] == drive_reg[0])
      else $error("drive select lost on pin 6");

   a_drive_out1: assert property (
      @(posedge clk) disable iff (!rst_n)
      dir_reg[1] |-> reducedDrive[1] == drive_reg[1])
      else $error("drive select lost on pin 7");

   a_pull_pushpull: assert property (
      @(posedge clk) disable iff (!rst_n)
      (dir_reg[0] && !wiredOrMode[0]) |-> !(pullUpEn[0] || pullDownEn[0]))
      else $error("pull on push-pull");

   a_pull_pushpull1: assert property (
      @(posedge clk) disable iff (!rst_n)
      (dir_reg[1] && !wiredOrMode[1]) |-> !(pullUpEn[1] || pullDownEn[1]))
      else $error("pull on push-pull 7");

   a_pull_input0: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!dir_reg[0] && pullEn_reg[0]) |-> (pullUpEn[0] || pullDownEn[0]))
      else $error("no pull on input 6");

   a_pull_input1: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!dir_reg[1] && pullEn_reg[1]) |-> (pullUpEn[1] || pullDownEn[1]))
      else $error("no pull on input 7");

   a_pull_wired0: assert property (
      @(posedge clk) disable iff (!rst_n)
      (dir_reg[0] && wiredOrMode[0] && pullEn_reg[0])
      |-> (pullUpEn[0] || pullDownEn[0]))
      else $error("no pull on wired-or 6");

   a_pull_off: assert property (
      @(posedge clk) disable iff (!rst_n)
      (pullEn_reg == 2'b00) |-> ((pullUpEn | pullDownEn) == 2'b00))
      else $error("pull without enable");

   a_pull_polar_up: assert property (
      @(posedge clk) disable iff (!rst_n)
      ((pullUpEn & polarity_reg) == 2'b00))
      else $error("pull-up with rising polarity");

   a_pull_polar_dn: assert property (
      @(posedge clk) disable iff (!rst_n)
      ((pullDownEn & ~polarity_reg) == 2'b00))
      else $error("pull-down with falling polarity");

   a_pull_exclusive: assert property (
      @(posedge clk) disable iff (!rst_n)
      ((pullUpEn & pullDownEn) == 2'b00))
      else $error("both pulls on");

   ////////////////////////////////////////////////////////////////////////
   // Assertions, synchroniser
   a_sync_stage1: assert property (
      @(posedge clk) disable iff (!rst_n)
      syncA_reg == $past(pinIn))
      else $error("first sync stage wrong");

   a_sync_latency: assert property (
      @(posedge clk) disable iff (!rst_n)
      ##2 syncB_reg == $past(pinIn, 2))
      else $error("sync depth wrong");

   c_wired_pull: cover property (@(posedge clk) disable iff (!rst_n)
      dir_reg[1] && wiredOrMode[1] && pullUpEn[1]);

   c_rise_irq: cover property (@(posedge clk) disable iff (!rst_n)
      polarity_reg[0] && edgeHit[0] ##1 irq);
   c_fall_flag: cover property (@(posedge clk) disable iff (!rst_n)
      !polarity_reg[1] && edgeHit[1]);
   c_clear_race: cover property (@(posedge clk) disable iff (!rst_n)
      edgeHit[0] && wrStb && addr == `OFS_IRQ_FLAGS && wrData[6]);
   c_read_in: cover property (@(posedge clk) disable iff (!rst_n)
      rdStb && addr == `OFS_OUT_DATA && !dir_reg[0]);
endmodule : two_pin_gpio_port
